// ===== hw/dma_err_swap.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - combined error bit sets on channel bus error or zero-code descriptor fetch.
// RULE2 - any such error disables the offending channel automatically.
// RULE3 - other channels keep enable, progress and status unchanged.
// RULE4 - writing one clears a combined error bit; zero does nothing; bits 30:0.
// RULE5 - combined error bit reads one while an error is pending.
// RULE6 - separate bus error register, one write-one-to-clear bit per channel.
// RULE7 - invalid descriptor bit sets when fetched cycle control is all zero.
// RULE8 - invalid descriptor bit reads pending state; write one clears it.
// RULE9 - writing one to swap-set enables swap; reads return swap enables.
// RULE10 - bit n maps to channel n; bit 31 reserved, reads zero.
// RULE11 - all status and swap bits are zero after reset.
// RULE12 - writing one to swap-clear disables swap for that channel.
// RULE13 - enabled swap reverses byte order of each data word for that channel.
// RULE14 - writes to the reserved top bit are ignored.
module dma_err_swap #(
  parameter int NCH = 31
) (
  input  wire logic                        mclk_i,
  input  wire logic                        srst_i,
  input  wire dma_err_swap_pkg::reg_req_s  req_i,
  output logic [31:0]                      rdata_o,
  input  wire dma_err_swap_pkg::per_channel_bits_evt_s evt_i,
  input  wire logic [4:0]                  data_per_channel_bits_i,
  input  wire logic [31:0]                 data_i,
  output logic [31:0]                      data_o,
  output logic [NCH-1:0]                   per_channel_bits_disable_o,
  output logic [NCH-1:0]                   swap_en_o,
  output logic                             irq_o
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire logic hit_cerr  = req_i.addr == dma_err_swap_pkg::PER_CHANNEL_BITS_ERR_ADDR;
  wire logic hit_berr  = req_i.addr == dma_err_swap_pkg::BUS_ERR_ADDR;
  wire logic hit_inv   = req_i.addr == dma_err_swap_pkg::INV_DESC_ADDR;
  wire logic hit_sset  = req_i.addr == dma_err_swap_pkg::SWAP_SET_ADDR;
  wire logic hit_sclr  = req_i.addr == dma_err_swap_pkg::SWAP_CLR_ADDR;
  wire logic hit_istat = req_i.addr == dma_err_swap_pkg::IRQ_STAT_ADDR;
  wire logic hit_imask = req_i.addr == dma_err_swap_pkg::IRQ_MASK_ADDR;

  // reserved bit 31 dropped here, so no write can reach it
  wire logic [NCH-1:0] wbits = req_i.wdata[NCH-1:0]; // RULE14

  // ------------------------------------------------------------
  // events
  // ------------------------------------------------------------
  wire logic [NCH-1:0] bus_ev = evt_i.bus_err[NCH-1:0];
  wire logic           cc_bad = evt_i.cycle_ctrl == dma_err_swap_pkg::CC_INVALID;
  wire logic [NCH-1:0] inv_ev = evt_i.desc_fetch[NCH-1:0] & {NCH{cc_bad}}; // RULE7

  logic [NCH-1:0] cerr_q, cerr_d;
  logic [NCH-1:0] berr_q, berr_d;
  logic [NCH-1:0] inv_q,  inv_d;
  logic [NCH-1:0] swap_q, swap_d;
  logic [NCH-1:0] dis_q,  dis_d;
  logic [dma_err_swap_pkg::IRQ_BITS-1:0] istat_q, istat_d;
  logic [dma_err_swap_pkg::IRQ_BITS-1:0] imask_q, imask_d;
  logic [31:0]    rdata_q, rdata_d;
  logic [31:0]    data_q,  data_d;
  logic           irq_q;

  wire logic w_cerr  = req_i.wr & hit_cerr;
  wire logic w_berr  = req_i.wr & hit_berr;
  wire logic w_inv   = req_i.wr & hit_inv;
  wire logic w_sset  = req_i.wr & hit_sset;
  wire logic w_sclr  = req_i.wr & hit_sclr;
  wire logic w_istat = req_i.wr & hit_istat;
  wire logic w_imask = req_i.wr & hit_imask;

  // ------------------------------------------------------------
  // write-one-to-clear and write-one-to-set masks per register
  // ------------------------------------------------------------
  wire logic [NCH-1:0] clr_cerr = {NCH{w_cerr}} & wbits; // RULE4
  wire logic [NCH-1:0] clr_berr = {NCH{w_berr}} & wbits; // RULE6
  wire logic [NCH-1:0] clr_inv  = {NCH{w_inv}} & wbits;  // RULE8
  wire logic [NCH-1:0] set_swap = {NCH{w_sset}} & wbits; // RULE9
  wire logic [NCH-1:0] clr_swap = {NCH{w_sclr}} & wbits; // RULE12

  // ------------------------------------------------------------
  // next values, per channel bit; error set beats clear, swap clear beats set
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // each bit only looks at its own channel's events and write bit
      assign cerr_d[g] = (bus_ev[g] | inv_ev[g]) | (cerr_q[g] & ~clr_cerr[g]); // RULE1 RULE4 RULE3
      assign berr_d[g] = bus_ev[g] | (berr_q[g] & ~clr_berr[g]); // RULE6
      assign inv_d[g]  = inv_ev[g] | (inv_q[g] & ~clr_inv[g]); // RULE8
      // clear wins over set whenever both land in one cycle, though one request address never hits both
      assign swap_d[g] = (swap_q[g] | set_swap[g]) & ~clr_swap[g]; // RULE9 RULE12
      // one-cycle disable pulse on the error event, independent of error status
      assign dis_d[g]  = bus_ev[g] | inv_ev[g]; // RULE2 RULE3
    end
  endgenerate

  wire logic [dma_err_swap_pkg::IRQ_BITS-1:0] irq_ev = {|inv_ev, |bus_ev};
  assign istat_d = irq_ev | (istat_q & ~({dma_err_swap_pkg::IRQ_BITS{w_istat}}
                   & req_i.wdata[dma_err_swap_pkg::IRQ_BITS-1:0]));
  assign imask_d = w_imask ? req_i.wdata[dma_err_swap_pkg::IRQ_BITS-1:0] : imask_q;

  // ------------------------------------------------------------
  // read mux, bit 31 always zero
  // ------------------------------------------------------------
  function automatic logic [31:0] widen(input logic [NCH-1:0] v);
    widen = {{(32 - NCH){1'b0}}, v};
  endfunction : widen

  always_comb begin
    if (!req_i.rd) begin
      rdata_d = 32'h0000_0000;
    end else if (hit_cerr) begin
      rdata_d = widen(cerr_q); // RULE5 RULE10
    end else if (hit_berr) begin
      rdata_d = widen(berr_q); // RULE10
    end else if (hit_inv) begin
      rdata_d = widen(inv_q); // RULE10
    end else if (hit_sset) begin
      rdata_d = widen(swap_q); // RULE9
    end else if (hit_istat) begin
      rdata_d = {30'h0, istat_q};
    end else if (hit_imask) begin
      rdata_d = {30'h0, imask_q};
    end else begin
      // write-only clear register and unmapped addresses read zero
      rdata_d = 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // data path byte swap, one cycle latency
  // ------------------------------------------------------------
  // channels beyond the implemented range never swap
  wire logic swap_sel = (data_per_channel_bits_i < 5'(NCH)) && swap_q[data_per_channel_bits_i];
  logic [31:0] swapped_w;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_byte
      assign swapped_w[8*b +: 8] = data_i[8*(3-b) +: 8]; // RULE13
    end
  endgenerate

  assign data_d = swap_sel ? swapped_w : data_i; // RULE13

  // ------------------------------------------------------------
  // interrupt next value
  // ------------------------------------------------------------
  // taken from next state so the line rises with the status bit
  wire logic irq_d = |(istat_d & imask_d);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // combined error status
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cerr_q <= '0; // RULE11
    end else begin
      cerr_q <= cerr_d;
    end
  end

  // ------------------------------------------------------------
  // bus error status
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      berr_q <= '0; // RULE11
    end else begin
      berr_q <= berr_d;
    end
  end

  // ------------------------------------------------------------
  // invalid descriptor status
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      inv_q <= '0; // RULE11
    end else begin
      inv_q <= inv_d;
    end
  end

  // ------------------------------------------------------------
  // byte swap enables
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      swap_q <= '0; // RULE11
    end else begin
      swap_q <= swap_d;
    end
  end

  // ------------------------------------------------------------
  // channel disable pulses
  // ------------------------------------------------------------
  // one-cycle pulse; the engine holds the channel off itself
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dis_q <= '0;
    end else begin
      dis_q <= dis_d;
    end
  end

  // ------------------------------------------------------------
  // interrupt status and mask
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      istat_q <= '0;
    end else begin
      istat_q <= istat_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      imask_q <= '0;
    end else begin
      imask_q <= imask_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ------------------------------------------------------------
  // read data and data path
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_q <= dma_err_swap_pkg::REG_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      data_q <= 32'h0000_0000;
    end else begin
      data_q <= data_d;
    end
  end

  // ------------------------------------------------------------
  // outputs, straight from flops
  // ------------------------------------------------------------

  assign rdata_o        = rdata_q;
  assign data_o         = data_q;
  assign per_channel_bits_disable_o = dis_q;
  assign swap_en_o      = swap_q;
  assign irq_o          = irq_q;

endmodule : dma_err_swap

// ===== hw/dma_err_swap_pkg.sv
package dma_err_swap_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [31:0] PER_CHANNEL_BITS_ERR_ADDR  = 32'h4004_0048;
  localparam logic [31:0] BUS_ERR_ADDR   = 32'h4004_004c;
  localparam logic [31:0] INV_DESC_ADDR  = 32'h4004_0050;
  localparam logic [31:0] SWAP_SET_ADDR  = 32'h4004_0800;
  localparam logic [31:0] SWAP_CLR_ADDR  = 32'h4004_0804;
  localparam logic [31:0] IRQ_STAT_ADDR  = 32'h4004_0900;
  localparam logic [31:0] IRQ_MASK_ADDR  = 32'h4004_0904;

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int          NUM_PER_CHANNEL_BITS       = 31;
  localparam int          RSVD_BIT       = 31;
  localparam logic [31:0] REG_RESET      = 32'h0000_0000;
  localparam logic [2:0]  CC_INVALID     = 3'h0;
  localparam int          IRQ_BUS_ERR    = 0;
  localparam int          IRQ_INV_DESC   = 1;
  localparam int          IRQ_BITS       = 2;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  typedef struct packed {
    logic [30:0] bus_err;
    logic [30:0] desc_fetch;
    logic [2:0]  cycle_ctrl;
  } per_channel_bits_evt_s;

endpackage : dma_err_swap_pkg

// ===== testbench/dma_err_swap_chk.sv
`timescale 1ns/1ps
module dma_err_swap_chk #(
  parameter int NCH = 31
) (
  input  wire logic                        mclk_i,
  input  wire logic                        srst_i,
  input  wire dma_err_swap_pkg::reg_req_s  req_i,
  input  wire logic [31:0]                 rdata_o,
  input  wire dma_err_swap_pkg::per_channel_bits_evt_s evt_i,
  input  wire logic [4:0]                  data_per_channel_bits_i,
  input  wire logic [31:0]                 data_i,
  input  wire logic [31:0]                 data_o,
  input  wire logic [NCH-1:0]              per_channel_bits_disable_o,
  input  wire logic [NCH-1:0]              swap_en_o,
  input  wire logic                        irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // invalid fetch only counts with the all-zero cycle control
  wire logic [30:0] inv_w = evt_i.desc_fetch & {31{evt_i.cycle_ctrl == dma_err_swap_pkg::CC_INVALID}};
  wire logic        set_w = req_i.wr && req_i.addr == dma_err_swap_pkg::SWAP_SET_ADDR;
  wire logic        clr_w = req_i.wr && req_i.addr == dma_err_swap_pkg::SWAP_CLR_ADDR;
  dis_bus_a: assert property (|evt_i.bus_err |=> (per_channel_bits_disable_o & $past(evt_i.bus_err)) == $past(evt_i.bus_err))
    else $error("channel not disabled after bus error");
  dis_only_a: assert property (|per_channel_bits_disable_o |-> (per_channel_bits_disable_o & ~$past(evt_i.bus_err | inv_w)) == 0)
    else $error("channel disabled without its own error");
  rsvd_a: assert property (rdata_o[31] == 1'b0)
    else $error("reserved bit read as one");
  swap_set_a: assert property (set_w |=> (swap_en_o & $past(req_i.wdata[30:0])) == $past(req_i.wdata[30:0]))
    else $error("swap enable not set");
  swap_clr_a: assert property (clr_w |=> (swap_en_o & $past(req_i.wdata[30:0])) == 0)
    else $error("swap enable not cleared");
  swap_hold_a: assert property (!set_w && !clr_w |=> $stable(swap_en_o))
    else $error("swap enable changed without a write");
  swap_rd_a: assert property (req_i.rd && req_i.addr == dma_err_swap_pkg::SWAP_SET_ADDR |=> rdata_o == 32'($past(swap_en_o)))
    else $error("swap enable read back wrong");
  swap_data_a: assert property (data_per_channel_bits_i == 5'h0 && swap_en_o[0] |=>
    data_o == {$past(data_i[7:0]), $past(data_i[15:8]), $past(data_i[23:16]), $past(data_i[31:24])})
    else $error("swapped word wrong");
  cover property (|evt_i.bus_err);
  cover property (|inv_w);
  cover property (irq_o);
endmodule : dma_err_swap_chk
bind dma_err_swap dma_err_swap_chk #(.NCH(NCH)) dma_err_swap_chk_inst (.*);

// ===== testbench/dma_bus_slave_model.sv
`timescale 1ns/1ps
module dma_bus_slave_model (
  input  wire logic                   mclk_i,
  output dma_err_swap_pkg::per_channel_bits_evt_s evt_o
);
  // idle cycle control is nonzero so a stray fetch strobe is harmless
  initial evt_o = '{31'h0, 31'h0, 3'h7};
  task automatic hit(input logic [30:0] be, input logic [30:0] df, input logic [2:0] cc);
    evt_o <= '{be, df, cc};
    @(posedge mclk_i);
    evt_o <= '{31'h0, 31'h0, 3'h7};
  endtask : hit
endmodule : dma_bus_slave_model

// ===== testbench/dma_err_swap_test.sv
`timescale 1ns/1ps
module dma_err_swap_test;
  localparam logic [31:0] CE = dma_err_swap_pkg::PER_CHANNEL_BITS_ERR_ADDR, BE = dma_err_swap_pkg::BUS_ERR_ADDR;
  localparam logic [31:0] IV = dma_err_swap_pkg::INV_DESC_ADDR, SS = dma_err_swap_pkg::SWAP_SET_ADDR;
  localparam logic [31:0] SC = dma_err_swap_pkg::SWAP_CLR_ADDR, IM = dma_err_swap_pkg::IRQ_MASK_ADDR;
  localparam logic [31:0] IS = dma_err_swap_pkg::IRQ_STAT_ADDR;
  localparam logic [31:0] REGS [5] = '{CE, BE, IV, SS, SC};
  logic mclk_i, srst_i, irq_o;
  logic [4:0] data_per_channel_bits_i;
  logic [31:0] data_i, data_o, rdata_o;
  logic [30:0] per_channel_bits_disable_o, swap_en_o;
  dma_err_swap_pkg::reg_req_s req;
  dma_err_swap_pkg::per_channel_bits_evt_s evt;
  int err_count = 0, n_compared = 0;
  dma_bus_slave_model slave_inst (.mclk_i(mclk_i), .evt_o(evt));
  dma_err_swap dma_err_swap_inst (.mclk_i(mclk_i), .srst_i(srst_i), .req_i(req), .rdata_o(rdata_o), .evt_i(evt),
    .data_per_channel_bits_i(data_per_channel_bits_i), .data_i(data_i), .data_o(data_o), .per_channel_bits_disable_o(per_channel_bits_disable_o),
    .swap_en_o(swap_en_o), .irq_o(irq_o));
  initial begin
    mclk_i = 0;
    forever #5 mclk_i = ~mclk_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [31:0] a, input logic [31:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk_i);
    req <= '0;
    @(posedge mclk_i);
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(input logic [31:0] a, input logic [31:0] exp);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk_i);
    req <= '0;
    @(negedge mclk_i);
    chk(rdata_o, exp);
    @(posedge mclk_i);
  endtask : rd
  task t_bus_err;
    slave_inst.hit(31'h8, 31'h0, 3'h7);
    @(negedge mclk_i);
    chk(32'(per_channel_bits_disable_o), 32'h8);
    @(posedge mclk_i);
    rd(CE, 32'h8);
    rd(BE, 32'h8);
    wr(CE, 32'h0);
    rd(CE, 32'h8);
    wr(CE, 32'h8000_0008);
    rd(CE, 32'h0);
    wr(BE, 32'h8);
    rd(BE, 32'h0);
  endtask : t_bus_err
  task t_inv;
    slave_inst.hit(31'h0, 31'h40, 3'h1);
    rd(IV, 32'h0);
    slave_inst.hit(31'h0, 31'h20, 3'h0);
    rd(IV, 32'h20);
    rd(CE, 32'h20);
    wr(IV, 32'h20);
    rd(IV, 32'h0);
  endtask : t_inv
  task t_swap;
    wr(SS, 32'h8000_0001);
    rd(SS, 32'h1);
    data_i <= 32'h1122_3344;
    @(posedge mclk_i);
    @(negedge mclk_i);
    chk(data_o, 32'h4433_2211);
    wr(SC, 32'h1);
    rd(SS, 32'h0);
    @(negedge mclk_i);
    chk(data_o, 32'h1122_3344);
    @(posedge mclk_i);
  endtask : t_swap
  task t_irq;
    wr(IS, 32'h3);
    rd(IS, 32'h0);
    wr(IM, 32'h1);
    @(negedge mclk_i);
    chk(32'(irq_o), 32'h0);
    @(posedge mclk_i);
    slave_inst.hit(31'h1, 31'h0, 3'h7);
    @(negedge mclk_i);
    chk(32'(irq_o), 32'h1);
    @(posedge mclk_i);
    rd(IS, 32'h1);
    wr(IM, 32'h0);
    @(negedge mclk_i);
    chk(32'(irq_o), 32'h0);
  endtask : t_irq
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #50us;
    err_count++;
    wrap_up();
  end
  initial begin
    srst_i = 1;
    req = '0;
    data_i = 0;
    data_per_channel_bits_i = 0;
    repeat (8) @(posedge mclk_i);
    srst_i <= 0;
    foreach (REGS[i]) rd(REGS[i], 32'h0);
    t_bus_err();
    t_inv();
    t_swap();
    t_irq();
    wrap_up();
  end
endmodule : dma_err_swap_test
